// file: sdcst_bank_ctrl.sv
// Two-bank SDRAM command state logic with read-beat FIFO and CAS latency drive.
`include "sdcst_params.svh"

module sdcst_bank_ctrl
  import sdcst_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic bank_sel_in,
  input wire logic [10:0] addr_in,
  input wire logic rd_ready_in,
  output logic [5:0] bank_state_out,
  output logic power_down_out,
  output logic self_refresh_out,
  output logic dq_oe_n_out,
  output logic rd_valid_out,
  output logic rd_bank_out,
  output logic [7:0] rd_col_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // --------------------------------------------------------------------------
  // Command decode and global state.
  // --------------------------------------------------------------------------
  sdcst_cmd_e cmd;
  logic cke_prev_r, cke_prev_nxt, pd_r, pd_nxt, sr_r, sr_nxt;
  logic [2:0] bl_r, bl_nxt, cl_r, cl_nxt;
  logic [1:0] pipe_r, pipe_nxt;
  logic oe_n_r, oe_n_nxt, en, all_idle, quiet;
  logic [8:0] blen;
  logic [1:0] beat;
  logic out_valid_r, out_valid_nxt, out_bank_r, out_bank_nxt;
  logic [7:0] out_col_r, out_col_nxt;
  sdcst_bank_state_e state_r [2];
  sdcst_bank_state_e state_nxt [2];
  logic [8:0] cnt_r [2];
  logic [8:0] cnt_nxt [2];
  logic [7:0] col_r [2];
  logic [7:0] col_nxt [2];
  logic [3:0] tmr_r [2];
  logic [3:0] tmr_nxt [2];
  logic ap_r [2];
  logic ap_nxt [2];
  sdcst_stream_if #(.WIDTH(`SDCST_FIFO_WIDTH)) fifo_if ();

  assign cmd = sdcst_decode(cs_n_in, ras_n_in, cas_n_in, we_n_in);
  assign blen = sdcst_burst_len(bl_r);
  assign all_idle = (state_r[0] == sdcst_idle) && (state_r[1] == sdcst_idle);
  assign quiet = (cmd == deselect_cmd) || (cmd == nop_cmd);
  // Internal clock runs only with clock enable high last edge and room for beats.
  assign en = cke_prev_r && !pd_r && !sr_r && fifo_if.in_ready;

  always_comb begin
    cke_prev_nxt = cke_in;
    pd_nxt = pd_r;
    sr_nxt = sr_r;
    bl_nxt = bl_r;
    cl_nxt = cl_r;
    if (pd_r) begin
      pd_nxt = !cke_in; // [R19]
    end else if (sr_r) begin
      sr_nxt = !(cke_in && quiet);
    end else if (cke_prev_r && !cke_in && all_idle) begin
      pd_nxt = quiet || (cmd == burst_stop_cmd); // [R01] [R19]
      sr_nxt = (cmd == refresh_cmd); // [R02]
    end
    if (en && all_idle && (cmd == mode_register_load_cmd)) begin
      bl_nxt = addr_in[`SDCST_BL_LSB +: 3]; // [R03]
      cl_nxt = addr_in[`SDCST_CL_LSB +: 3];
    end
    // Output drive follows the beat stream by three cycles at CAS latency 3 and two otherwise, so a burst stop
    // still lets the beats already in flight reach the pins.
    pipe_nxt = {pipe_r[0], |beat}; // [R17]
    oe_n_nxt = (cl_r == 3'h3) ? !pipe_r[1] : !pipe_r[0]; // [R17]
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cke_prev_r <= 1'b0;
      pd_r <= 1'b0;
      sr_r <= 1'b0;
      bl_r <= `SDCST_BL_RST;
      cl_r <= `SDCST_CL_RST;
      pipe_r <= 2'h0;
      oe_n_r <= 1'b1;
    end else begin
      cke_prev_r <= cke_prev_nxt;
      pd_r <= pd_nxt;
      sr_r <= sr_nxt;
      bl_r <= bl_nxt;
      cl_r <= cl_nxt;
      pipe_r <= pipe_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Per-bank state machines.
  // --------------------------------------------------------------------------
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic hit, pre_hit, other_rw;
    assign hit = (bank_sel_in == 1'(b));
    assign pre_hit = (cmd == precharge_cmd) && (hit || addr_in[`SDCST_AP_BIT]);
    assign other_rw = !hit && ((cmd == read_cmd) || (cmd == write_cmd));

    always_comb begin
      state_nxt[b] = state_r[b];
      cnt_nxt[b] = cnt_r[b];
      col_nxt[b] = col_r[b];
      tmr_nxt[b] = tmr_r[b];
      ap_nxt[b] = ap_r[b];
      beat[b] = 1'b0;
      if (en) begin
        if (tmr_r[b] != 4'h0) begin
          tmr_nxt[b] = tmr_r[b] - 4'h1;
        end
        if ((state_r[b] == sdcst_read) || (state_r[b] == sdcst_read_ap) ||
            (state_r[b] == sdcst_write)) begin
          cnt_nxt[b] = cnt_r[b] - 9'h001;
          col_nxt[b] = col_r[b] + 8'h01;
          beat[b] = (state_r[b] != sdcst_write);
        end
        case (state_r[b])
          sdcst_idle: begin
            if ((cmd == row_activate_cmd) && hit) begin
              state_nxt[b] = sdcst_active; // [R03]
            end else if ((cmd == refresh_cmd) && all_idle && cke_in) begin
              state_nxt[b] = sdcst_refresh; // [R02]
              tmr_nxt[b] = `SDCST_RC_CYC;
            end
          end
          sdcst_active, sdcst_read, sdcst_write: begin
            if (hit && (cmd == read_cmd)) begin
              state_nxt[b] = addr_in[`SDCST_AP_BIT] ? sdcst_read_ap : sdcst_read; // [R04] [R07] [R12]
              cnt_nxt[b] = blen;
              col_nxt[b] = addr_in[7:0];
            end else if (hit && (cmd == write_cmd)) begin
              state_nxt[b] = sdcst_write; // [R04] [R08] [R13]
              ap_nxt[b] = addr_in[`SDCST_AP_BIT];
              cnt_nxt[b] = blen;
              col_nxt[b] = addr_in[7:0];
            end else if (pre_hit) begin
              state_nxt[b] = sdcst_precharge; // [R04] [R09] [R14]
              tmr_nxt[b] = `SDCST_RP_CYC;
            end else if (state_r[b] == sdcst_active) begin
              state_nxt[b] = sdcst_active; // [R04] [R18]
            end else if (cmd == burst_stop_cmd) begin
              state_nxt[b] = sdcst_active; // [R06] [R11]
            end else if (state_r[b] == sdcst_write && (other_rw || cnt_r[b] == 9'h001)) begin
              state_nxt[b] = sdcst_write_recov; // [R10]
              tmr_nxt[b] = `SDCST_WR_CYC;
            end else if (other_rw || cnt_r[b] == 9'h001) begin
              state_nxt[b] = sdcst_active; // [R05]
            end
          end
          sdcst_read_ap: begin
            if (cnt_r[b] == 9'h001) begin
              state_nxt[b] = sdcst_precharge; // [R15] [R16]
              tmr_nxt[b] = `SDCST_RP_CYC;
            end
          end
          sdcst_write_recov: begin
            if (tmr_nxt[b] == 4'h0) begin
              state_nxt[b] = ap_r[b] ? sdcst_precharge : sdcst_active;
              tmr_nxt[b] = ap_r[b] ? `SDCST_RP_CYC : 4'h0;
              ap_nxt[b] = 1'b0;
            end
          end
          sdcst_precharge, sdcst_refresh: begin
            if (tmr_nxt[b] == 4'h0) begin
              state_nxt[b] = sdcst_idle;
            end
          end
          default: begin
            state_nxt[b] = sdcst_idle;
          end
        endcase
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
        state_r[b] <= sdcst_idle;
        cnt_r[b] <= 9'h000;
        col_r[b] <= 8'h00;
        tmr_r[b] <= 4'h0;
        ap_r[b] <= 1'b0;
      end else begin
        state_r[b] <= state_nxt[b];
        cnt_r[b] <= cnt_nxt[b];
        col_r[b] <= col_nxt[b];
        tmr_r[b] <= tmr_nxt[b];
        ap_r[b] <= ap_nxt[b];
      end
    end

    a_idle_quiet_holds: assert property ( // [R01] [R18]
      (en && state_r[b] == sdcst_idle && (quiet || cmd == burst_stop_cmd))
      |=> state_r[b] == sdcst_idle) else $error("Idle bank left idle on a quiet command");
    a_act_opens_row: assert property ( // [R03]
      (en && state_r[b] == sdcst_idle && cmd == row_activate_cmd && hit)
      |=> state_r[b] == sdcst_active) else $error("Activate did not open the row");
    a_read_runs_out: assert property ( // [R05]
      (en && state_r[b] == sdcst_read && quiet && cnt_r[b] == 9'h001)
      |=> state_r[b] == sdcst_active) else $error("Read burst did not end in row active");
    a_stop_to_active: assert property ( // [R06] [R11]
      (en && (state_r[b] == sdcst_read || state_r[b] == sdcst_write) &&
       cmd == burst_stop_cmd) |=> state_r[b] == sdcst_active)
      else $error("Burst stop did not return to row active");
    a_read_restart_col: assert property ( // [R07] [R12]
      (en && (state_r[b] == sdcst_read || state_r[b] == sdcst_write) &&
       cmd == read_cmd && hit) |=> (col_r[b] == $past(addr_in[7:0]) &&
       cnt_r[b] == blen)) else $error("Read restart took the wrong column");
    a_write_restart: assert property ( // [R08] [R13]
      (en && (state_r[b] == sdcst_read || state_r[b] == sdcst_write) &&
       cmd == write_cmd && hit) |=> state_r[b] == sdcst_write)
      else $error("Write did not start a write burst");
    a_burst_precharge: assert property ( // [R09] [R14]
      (en && (state_r[b] == sdcst_read || state_r[b] == sdcst_write) && pre_hit)
      |=> state_r[b] == sdcst_precharge) else $error("Precharge did not cut the burst");
    a_write_recovery: assert property ( // [R10]
      (en && state_r[b] == sdcst_write && quiet && cnt_r[b] == 9'h001)
      |=> state_r[b] == sdcst_write_recov) else $error("Write burst skipped recovery");
    a_auto_precharge: assert property ( // [R15]
      (en && state_r[b] == sdcst_read_ap && cnt_r[b] == 9'h001)
      |=> state_r[b] == sdcst_precharge) else $error("Auto-precharge did not follow read");
  end

  a_refresh_start: assert property ( // [R02]
    (en && all_idle && cmd == refresh_cmd && cke_in)
    |=> (state_r[0] == sdcst_refresh && state_r[1] == sdcst_refresh))
    else $error("Refresh did not start on both banks");
  a_self_refresh_in: assert property ( // [R02]
    (cke_prev_r && !cke_in && !pd_r && !sr_r && all_idle && cmd == refresh_cmd)
    |=> sr_r ##1 sr_r) else $error("Self-refresh not entered");
  a_drive_latency: assert property ( // [R17]
    (|beat && cl_r == 3'h3) |-> ##3 !dq_oe_n_out) else $error("Output drive missed the latency");
  a_power_down_hold: assert property ( // [R19]
    (pd_r && !cke_in) |=> pd_r) else $error("Power-down left while clock enable low");

  // --------------------------------------------------------------------------
  // Read-beat FIFO and registered output stage.
  // --------------------------------------------------------------------------
  assign fifo_if.in_valid = |beat;
  assign fifo_if.in_data = beat[1] ? {1'b1, col_r[1]} : {1'b0, col_r[0]};
  assign fifo_if.out_ready = !out_valid_r || rd_ready_in;

  sdcst_fifo #(.WIDTH(`SDCST_FIFO_WIDTH), .DEPTH(`SDCST_FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .s(fifo_if.fifo_mp)
  );

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_bank_nxt = out_bank_r;
    out_col_nxt = out_col_r;
    if (fifo_if.out_ready) begin
      out_valid_nxt = fifo_if.out_valid;
      out_bank_nxt = fifo_if.out_data[8];
      out_col_nxt = fifo_if.out_data[7:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      out_valid_r <= 1'b0;
      out_bank_r <= 1'b0;
      out_col_r <= 8'h00;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_bank_r <= out_bank_nxt;
      out_col_r <= out_col_nxt;
    end
  end

  assign bank_state_out = {state_r[1], state_r[0]};
  assign power_down_out = pd_r;
  assign self_refresh_out = sr_r;
  assign dq_oe_n_out = oe_n_r;
  assign rd_valid_out = out_valid_r;
  assign rd_bank_out = out_bank_r;
  assign rd_col_out = out_col_r;

endmodule // sdcst_bank_ctrl

// file: sdcst_params.svh
// Timing, reset and field constants of the SDRAM bank command state logic.
//
// Overview of operation
// R01: Idle bank ignores deselect, no-op, burst stop.
// R02: Refresh with banks idle; self-refresh if clock enable low.
// R03: Idle: activate opens row, mode load, precharge ignored.
// R04: Active: read/write start burst, precharge closes row.
// R05: Read burst runs its length, then row active.
// R06: Burst stop ends read, bank stays active.
// R07: New read restarts read burst at new column.
// R08: Write during read aborts read, starts write.
// R09: Precharge during read cuts burst, then precharges.
// R10: Write burst completes, then write recovery.
// R11: Burst stop ends write, bank stays active.
// R12: Read during write ends write, starts read.
// R13: New write restarts write at new column.
// R14: Precharge during write ends burst, then precharges.
// R15: Read with auto-precharge finishes, then precharges automatically.
// R16: Controller avoids illegal commands in burst states.
// R17: After burst stop, data drives through CAS latency.
// R18: Deselect has no effect in any state.
// R19: Power-down on clock enable fall, held while low; code needs both banks idle and a no-op, deselect or burst stop.
`ifndef SDCST_PARAMS_SVH
`define SDCST_PARAMS_SVH
`define SDCST_CLK_MHZ 100
`define SDCST_T_RP_NS 20
`define SDCST_T_WR_NS 20
`define SDCST_T_RC_NS 70
`define SDCST_RP_CYC 4'(((`SDCST_T_RP_NS * `SDCST_CLK_MHZ) + 999) / 1000)
`define SDCST_WR_CYC 4'(((`SDCST_T_WR_NS * `SDCST_CLK_MHZ) + 999) / 1000)
`define SDCST_RC_CYC 4'(((`SDCST_T_RC_NS * `SDCST_CLK_MHZ) + 999) / 1000)
`define SDCST_BL_LSB 0
`define SDCST_CL_LSB 4
`define SDCST_AP_BIT 10
`define SDCST_BL_RST 3'h0
`define SDCST_CL_RST 3'h3
`define SDCST_FIFO_DEPTH 32
`define SDCST_FIFO_WIDTH 9
`endif

// file: sdcst_pkg.sv
// Types and decoding functions of the SDRAM bank command state logic.
package sdcst_pkg;

  typedef enum logic [2:0] {
    sdcst_idle = 3'h0,
    sdcst_active = 3'h1,
    sdcst_read = 3'h3,
    sdcst_read_ap = 3'h2,
    sdcst_write = 3'h5,
    sdcst_write_recov = 3'h4,
    sdcst_precharge = 3'h6,
    sdcst_refresh = 3'h7
  } sdcst_bank_state_e;

  typedef enum logic [3:0] {
    deselect_cmd = 4'h0,
    nop_cmd = 4'h1,
    burst_stop_cmd = 4'h2,
    read_cmd = 4'h3,
    write_cmd = 4'h4,
    row_activate_cmd = 4'h5,
    precharge_cmd = 4'h6,
    refresh_cmd = 4'h7,
    mode_register_load_cmd = 4'h8
  } sdcst_cmd_e;

  function automatic sdcst_cmd_e sdcst_decode(input logic cs_n, input logic ras_n,
                                              input logic cas_n, input logic we_n);
    sdcst_cmd_e c;
    if (cs_n) begin
      c = deselect_cmd;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'b111: c = nop_cmd;
        3'b110: c = burst_stop_cmd;
        3'b101: c = read_cmd;
        3'b100: c = write_cmd;
        3'b011: c = row_activate_cmd;
        3'b010: c = precharge_cmd;
        3'b001: c = refresh_cmd;
        default: c = mode_register_load_cmd;
      endcase
    end
    return c;
  endfunction

  function automatic logic [8:0] sdcst_burst_len(input logic [2:0] code);
    logic [8:0] len;
    case (code)
      3'h0: len = 9'h001;
      3'h1: len = 9'h002;
      3'h2: len = 9'h004;
      3'h3: len = 9'h008;
      default: len = 9'h100;
    endcase
    return len;
  endfunction

endpackage

// file: sdcst_stream_if.sv
// Valid/ready stream between the bank logic and its read-beat FIFO.
interface sdcst_stream_if #(
  parameter int WIDTH = 9
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo_mp (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
  modport user_mp (output in_valid, output in_data, output out_ready,
                   input in_ready, input out_valid, input out_data);
endinterface

// file: sdcst_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
module sdcst_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  sdcst_stream_if.fifo_mp s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  assign s.in_ready = (count_r != (AW+1)'(DEPTH));
  assign s.out_valid = (count_r != '0);
  assign s.out_data = mem[rd_ptr_r];
  assign push = s.in_valid && s.in_ready;
  assign pop = s.out_valid && s.out_ready;

  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= s.in_data;
    end
  end

  a_fifo_count_bound: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    count_r <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
  a_fifo_full_holds: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (!s.in_ready && !pop) |=> !s.in_ready) else $error("Full flag dropped without a pop");

endmodule // sdcst_fifo

// file: sdcst_ctrl_model.sv
// Memory controller model: drives commands on the falling edge and takes read beats.
module sdcst_ctrl_model
  import sdcst_pkg::*;
(
  input wire logic ref_clk_in,
  output logic cke_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic bank_sel_out,
  output logic [10:0] addr_out,
  output logic rd_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cke_out = 1'b1;
    cs_n_out = 1'b0;
    {ras_n_out, cas_n_out, we_n_out} = 3'h7;
    bank_sel_out = 1'b0;
    addr_out = 11'h000;
    rd_ready_out = 1'b1;
  end

  // Callers only send what the current state allows, so no illegal command is issued.
  task automatic issue(input sdcst_cmd_e cmd, input logic bank, input logic [10:0] addr,
                       input logic cke = 1'b1);
    @(negedge ref_clk_in);
    cke_out = cke;
    cs_n_out = (cmd == deselect_cmd);
    case (cmd)
      burst_stop_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h6;
      read_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h5;
      write_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h4;
      row_activate_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h3;
      precharge_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h2;
      refresh_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h1;
      mode_register_load_cmd: {ras_n_out, cas_n_out, we_n_out} = 3'h0;
      default: {ras_n_out, cas_n_out, we_n_out} = 3'h7;
    endcase
    bank_sel_out = bank;
    addr_out = addr;
  endtask

  // Address and bank lines carry no meaning with a no-op, so they show the inverse.
  task automatic quiet();
    @(negedge ref_clk_in);
    cs_n_out = 1'b0;
    {ras_n_out, cas_n_out, we_n_out} = 3'h7;
    bank_sel_out = ~bank_sel_out;
    addr_out = ~addr_out;
  endtask

  // A no-op goes out with the ready change so that no earlier command is repeated.
  task automatic set_ready(input logic v);
    @(negedge ref_clk_in);
    cs_n_out = 1'b0;
    {ras_n_out, cas_n_out, we_n_out} = 3'h7;
    rd_ready_out = v;
  endtask
endmodule // sdcst_ctrl_model

// file: sdcst_bank_ctrl_tb.sv
// Self-checking testbench of the SDRAM bank command state logic.
module sdcst_bank_ctrl_tb
  import sdcst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_sel, rd_ready;
  logic [10:0] addr;
  logic [5:0] bank_state;
  logic power_down, self_refresh, dq_oe_n, rd_valid, rd_bank;
  logic [7:0] rd_col;
  logic [8:0] beats[$];
  int failures = 0;
  int check_count = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  sdcst_ctrl_model ctl (.ref_clk_in(ref_clk_in), .cke_out(cke), .cs_n_out(cs_n),
    .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .bank_sel_out(bank_sel),
    .addr_out(addr), .rd_ready_out(rd_ready));

  sdcst_bank_ctrl DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cke_in(cke),
    .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
    .bank_sel_in(bank_sel), .addr_in(addr), .rd_ready_in(rd_ready),
    .bank_state_out(bank_state), .power_down_out(power_down),
    .self_refresh_out(self_refresh), .dq_oe_n_out(dq_oe_n), .rd_valid_out(rd_valid),
    .rd_bank_out(rd_bank), .rd_col_out(rd_col));

  always @(posedge ref_clk_in) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      beats.push_back({rd_bank, rd_col});
    end
  end

  // ----------------------------------------
  // Shared checks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [2:0] st(input logic bank);
    return bank ? bank_state[5:3] : bank_state[2:0];
  endfunction

  task automatic wait_state(input logic bank, input sdcst_bank_state_e exp, input int max);
    int n;
    n = 0;
    while (st(bank) !== exp && n < max) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("bank state", 16'(st(bank)), 16'(exp));
  endtask

  // Flag 0 is power-down, 1 is self-refresh, 2 is the active-low data drive.
  task automatic wait_flag(input int idx, input logic exp, input int max);
    logic [2:0] f;
    int n;
    n = 0;
    f = {dq_oe_n, self_refresh, power_down};
    while (f[idx] !== exp && n < max) begin
      @(negedge ref_clk_in);
      n++;
      f = {dq_oe_n, self_refresh, power_down};
    end
    check("flag", 16'(f[idx]), 16'(exp));
  endtask

  task automatic results();
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle();
    sdcst_cmd_e quiet_cmds[6];
    quiet_cmds = '{nop_cmd, burst_stop_cmd, deselect_cmd, precharge_cmd, precharge_cmd, nop_cmd};
    check("reset outputs", 16'({bank_state, power_down, self_refresh, dq_oe_n, rd_valid}),
          16'h0002);
    foreach (quiet_cmds[i]) begin
      ctl.issue(quiet_cmds[i], 1'b0, (i == 4) ? 11'h400 : 11'h000);
      ctl.quiet();
      check("idle state", 16'(bank_state), 16'h0000);
    end
    ctl.issue(mode_register_load_cmd, 1'b0, 11'h032);
    ctl.quiet();
    check("idle after mode", 16'(bank_state), 16'h0000);
  endtask

  task automatic t_read();
    beats.delete();
    ctl.issue(row_activate_cmd, 1'b0, 11'h155);
    ctl.quiet();
    check("activate", 16'(st(1'b0)), 16'(sdcst_active));
    ctl.issue(read_cmd, 1'b0, 11'h005);
    ctl.quiet();
    check("read start", 16'(st(1'b0)), 16'(sdcst_read));
    wait_state(1'b0, sdcst_active, 10);
    repeat (6) @(negedge ref_clk_in);
    check("beat count", 16'(beats.size()), 16'h0004);
    check("last column", 16'(beats[$]), 16'h0008);
  endtask

  task automatic t_stop();
    ctl.issue(read_cmd, 1'b0, 11'h00A);
    ctl.issue(burst_stop_cmd, 1'b0, 11'h000);
    ctl.quiet();
    check("after stop", 16'(st(1'b0)), 16'(sdcst_active));
    wait_flag(2, 1'b0, 4);
    wait_flag(2, 1'b1, 6);
    beats.delete();
    ctl.issue(read_cmd, 1'b0, 11'h020);
    ctl.issue(read_cmd, 1'b0, 11'h040);
    ctl.quiet();
    wait_state(1'b0, sdcst_active, 10);
    repeat (6) @(negedge ref_clk_in);
    check("restart column", 16'(beats[$]), 16'h0043);
  endtask

  task automatic t_rw();
    ctl.issue(read_cmd, 1'b0, 11'h010);
    ctl.issue(write_cmd, 1'b0, 11'h020);
    ctl.quiet();
    check("read to write", 16'(st(1'b0)), 16'(sdcst_write));
    ctl.issue(burst_stop_cmd, 1'b0, 11'h000);
    ctl.quiet();
    check("write stop", 16'(st(1'b0)), 16'(sdcst_active));
    ctl.issue(write_cmd, 1'b0, 11'h030);
    ctl.issue(read_cmd, 1'b0, 11'h040);
    ctl.quiet();
    check("write to read", 16'(st(1'b0)), 16'(sdcst_read));
    wait_state(1'b0, sdcst_active, 8);
    ctl.issue(write_cmd, 1'b0, 11'h050);
    ctl.issue(write_cmd, 1'b0, 11'h060);
    ctl.quiet();
    check("write restart", 16'(st(1'b0)), 16'(sdcst_write));
    wait_state(1'b0, sdcst_write_recov, 8);
    wait_state(1'b0, sdcst_active, 4);
  endtask

  task automatic t_pre();
    ctl.issue(read_cmd, 1'b0, 11'h070);
    ctl.issue(precharge_cmd, 1'b0, 11'h000);
    ctl.quiet();
    wait_state(1'b0, sdcst_precharge, 2);
    wait_state(1'b0, sdcst_idle, 4);
    ctl.issue(row_activate_cmd, 1'b0, 11'h123);
    ctl.issue(row_activate_cmd, 1'b1, 11'h124);
    ctl.issue(write_cmd, 1'b0, 11'h080);
    ctl.issue(precharge_cmd, 1'b0, 11'h400);
    ctl.quiet();
    check("both precharge", 16'(bank_state), 16'h0036);
    wait_state(1'b1, sdcst_idle, 4);
    beats.delete();
    ctl.issue(row_activate_cmd, 1'b0, 11'h200);
    ctl.issue(read_cmd, 1'b0, 11'h4F0);
    ctl.quiet();
    check("read auto", 16'(st(1'b0)), 16'(sdcst_read_ap));
    wait_state(1'b0, sdcst_precharge, 8);
    wait_state(1'b0, sdcst_idle, 4);
    check("auto beats", 16'({beats.size() == 4, beats[$]}), 16'h02F3);
  endtask

  task automatic t_power();
    ctl.issue(refresh_cmd, 1'b0, 11'h000);
    ctl.quiet();
    check("refresh", 16'(bank_state), 16'h003F);
    wait_state(1'b0, sdcst_idle, 10);
    ctl.issue(refresh_cmd, 1'b0, 11'h000, 1'b0);
    ctl.quiet();
    wait_flag(1, 1'b1, 3);
    ctl.issue(nop_cmd, 1'b0, 11'h000, 1'b1);
    ctl.quiet();
    wait_flag(1, 1'b0, 3);
    ctl.issue(nop_cmd, 1'b0, 11'h000, 1'b0);
    ctl.quiet();
    wait_flag(0, 1'b1, 3);
    repeat (6) @(negedge ref_clk_in);
    check("held down", 16'({power_down, bank_state}), 16'h0040);
    ctl.issue(nop_cmd, 1'b0, 11'h000, 1'b1);
    ctl.quiet();
    wait_flag(0, 1'b0, 3);
  endtask

  task automatic t_fifo();
    ctl.issue(mode_register_load_cmd, 1'b0, 11'h024);
    ctl.issue(row_activate_cmd, 1'b1, 11'h010);
    ctl.set_ready(1'b0);
    beats.delete();
    ctl.issue(read_cmd, 1'b1, 11'h010);
    ctl.quiet();
    repeat (60) @(negedge ref_clk_in);
    check("stalled", 16'({beats.size() == 0, st(1'b1)}), 16'h000B);
    ctl.set_ready(1'b1);
    wait_flag(2, 1'b0, 4);
    wait_state(1'b1, sdcst_active, 400);
    repeat (40) @(negedge ref_clk_in);
    check("page beats", 16'(beats.size()), 16'h0100);
    check("page wrap", 16'(beats[$]), 16'h010F);
  endtask

  initial begin
    repeat (16) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    ctl.quiet();
    ctl.quiet();
    t_idle();
    t_read();
    t_stop();
    t_rw();
    t_pre();
    t_power();
    t_fifo();
    results();
  end

  initial begin
    #300_000;
    failures++;
    results();
  end
endmodule // sdcst_bank_ctrl_tb
